/* verilog/pif_regs.vh */
// Register map, field positions and reset values of the peripheral interrupt flag block.
// Assumes a 32-bit APB slave with word-aligned registers; data sits in the low eight bits, thirteen for the return PC.
`ifndef PIF_REGS_VH
`define PIF_REGS_VH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define PIF_OFS_INTERRUPT_CONTROL     12'h000
`define PIF_OFS_PERIPHERAL_ENABLE_TWO 12'h004
`define PIF_OFS_PERIPHERAL_FLAGS_TWO  12'h008
`define PIF_OFS_EDGE_SELECT           12'h00c
`define PIF_OFS_STATUS                12'h010
`define PIF_OFS_MASK                  12'h014
`define PIF_OFS_RET_PC                12'h018
`define PIF_OFS_COMMON_RAM            12'h040
`define PIF_OFS_COMMON_RAM_END        12'h07c

// ----------------------------------------------------------------
// Fields
// ----------------------------------------------------------------
`define PIF_BIT_DESAT        7
`define PIF_BIT_CONV_DONE    6
`define PIF_BIT_UNUSED       5
`define PIF_BIT_OVERTEMP     4
`define PIF_BIT_OUT_OV       3
`define PIF_BIT_GATE_LOW     2
`define PIF_BIT_IN_OV        1
`define PIF_BIT_IN_UV        0
`define PIF_BIT_GLOBAL_EN    7
`define PIF_BIT_GROUP_EN     6
`define PIF_IMPL_MASK        8'hdf
`define PIF_SEL_OUT_OV_RISE  0
`define PIF_SEL_OUT_OV_FALL  1
`define PIF_SEL_IN_OV_RISE   2
`define PIF_SEL_IN_OV_FALL   3
`define PIF_SEL_IN_UV_RISE   4
`define PIF_SEL_IN_UV_FALL   5
`define PIF_STAT_FLAG        0
`define PIF_STAT_ENTRY       1

// ----------------------------------------------------------------
// Reset values and sizes
// ----------------------------------------------------------------
`define PIF_RST_BYTE         8'h00
`define PIF_RST_EDGE_SELECT  8'h15
`define PIF_RAM_WORDS        16
`define PIF_PC_W             13

`endif

/* verilog/pif_flags.v */
// Second peripheral interrupt flag register, interrupt entry and bank-common scratch RAM.
// Assumes event inputs may be asynchronous and that an APB master on core_clk_i owns the map.
// Notes on behaviour
// - The desaturation flag in bit 7 is set when the desaturation comparator signals an event.
// - The converter-done flag in bit 6 is set when a conversion completes and is clear before.
// - Bit 5 of the flag register is unimplemented and always reads zero.
// - The over-temperature flag in bit 4 is set when an over-temperature event occurs.
// - The output overvoltage flag in bit 3 is set on entry with rise select, exit with fall select.
// - The gate-drive undervoltage flag in bit 2 is set when the gate supply lockout occurs.
// - The input overvoltage flag in bit 1 is set on its selected entry or exit edge.
// - The input undervoltage flag in bit 0 is set on its selected entry or exit edge.
// - On interrupt entry only the return program counter is pushed; nothing else is saved.
// - Sixteen common RAM bytes are reachable at one address independent of bank selection.
// - Every flag is set on its event whatever its enable or the global enable holds.
// - No peripheral request reaches the core unless the peripheral group enable is set.
//
// The register addresses and the APB slave port were left to the implementer.
`timescale 1ns/100ps
`include "pif_regs.vh"

module pif_flags (
   // Clock and reset
   input  wire                      core_clk_i,
   input  wire                      reset_i,
   // APB slave
   input  wire                      psel_i,
   input  wire                      penable_i,
   input  wire                      pwrite_i,
   input  wire [11:0]               paddr_i,
   input  wire [31:0]               pwdata_i,
   output reg  [31:0]               prdata_o,
   output reg                       pready_o,
   output reg                       pslverr_o,
   // Analog monitor events, asynchronous levels
   input  wire                      desat_i,
   input  wire                      conv_done_i,
   input  wire                      overtemp_i,
   input  wire                      out_overvolt_i,
   input  wire                      gate_supply_low_i,
   input  wire                      in_overvolt_i,
   input  wire                      in_undervolt_i,
   // Core side
   input  wire                      irq_ack_i,
   input  wire [`PIF_PC_W-1:0]      core_pc_i,
   output reg                       core_irq_o,
   output reg                       push_pc_o,
   output reg  [`PIF_PC_W-1:0]      push_pc_data_o,
   // Block interrupt
   output reg                       irq_o
);

   // ----------------------------------------------------------------
   // Registers and wires
   // ----------------------------------------------------------------
   reg  [6:0]             sync_a;
   reg  [6:0]             sync_b;
   reg  [6:0]             sync_prev;
   reg  [7:0]             interrupt_control;
   reg  [7:0]             peripheral_enable_two;
   reg  [7:0]             peripheral_flags_two;
   reg  [7:0]             edge_select;
   reg  [1:0]             status;
   reg  [1:0]             mask;
   reg  [`PIF_PC_W-1:0]   ret_pc;
   reg  [7:0]             common_ram [0:`PIF_RAM_WORDS-1];
   reg  [7:0]             event_hit;
   reg  [7:0]             next_flags;
   reg  [31:0]            next_rdata;
   reg                    next_err;
   wire                   access;
   wire                   wr;
   wire                   ram_hit;
   wire [3:0]             ram_idx;
   wire [6:0]             rise;
   wire [6:0]             fall;
   wire                   group_req;
   wire                   core_req;
   wire [1:0]             stat_set;

   assign access    = psel_i & penable_i & ~pready_o;
   assign wr        = access & pwrite_i;
   assign ram_hit   = (paddr_i >= `PIF_OFS_COMMON_RAM) && (paddr_i <= `PIF_OFS_COMMON_RAM_END)
                      && (paddr_i[1:0] == 2'b00);
   assign ram_idx   = paddr_i[5:2];
   assign rise      = sync_b & ~sync_prev;
   assign fall      = ~sync_b & sync_prev;

   // ----------------------------------------------------------------
   // Event synchronisers
   // ----------------------------------------------------------------
   always @(posedge core_clk_i or posedge reset_i) begin
      if (reset_i) begin
         sync_a    <= 7'h00;
         sync_b    <= 7'h00;
         sync_prev <= 7'h00;
      end else begin
         sync_a    <= {desat_i, conv_done_i, overtemp_i, out_overvolt_i,
                       gate_supply_low_i, in_overvolt_i, in_undervolt_i};
         sync_b    <= sync_a;
         sync_prev <= sync_b;
      end
   end

   // ----------------------------------------------------------------
   // Flag setting
   // ----------------------------------------------------------------
   always @* begin
      event_hit = 8'h00;
      event_hit[`PIF_BIT_DESAT]     = rise[6];
      event_hit[`PIF_BIT_CONV_DONE] = rise[5];
      event_hit[`PIF_BIT_OVERTEMP]  = rise[4];
      event_hit[`PIF_BIT_OUT_OV]    = (rise[3] & edge_select[`PIF_SEL_OUT_OV_RISE])
                                    | (fall[3] & edge_select[`PIF_SEL_OUT_OV_FALL]);
      event_hit[`PIF_BIT_GATE_LOW]  = rise[2];
      event_hit[`PIF_BIT_IN_OV]     = (rise[1] & edge_select[`PIF_SEL_IN_OV_RISE])
                                    | (fall[1] & edge_select[`PIF_SEL_IN_OV_FALL]);
      event_hit[`PIF_BIT_IN_UV]     = (rise[0] & edge_select[`PIF_SEL_IN_UV_RISE])
                                    | (fall[0] & edge_select[`PIF_SEL_IN_UV_FALL]);
      next_flags = peripheral_flags_two;
      if (wr && paddr_i == `PIF_OFS_PERIPHERAL_FLAGS_TWO) begin
         next_flags = pwdata_i[7:0];
      end
      next_flags = (next_flags | event_hit) & `PIF_IMPL_MASK;
   end

   assign group_req = |(peripheral_flags_two & peripheral_enable_two);
   assign core_req  = group_req & interrupt_control[`PIF_BIT_GROUP_EN]
                      & interrupt_control[`PIF_BIT_GLOBAL_EN];
   assign stat_set  = {core_req & ~core_irq_o, |event_hit};

   // ----------------------------------------------------------------
   // Register file
   // ----------------------------------------------------------------
   always @(posedge core_clk_i or posedge reset_i) begin
      if (reset_i) begin
         interrupt_control     <= `PIF_RST_BYTE;
         peripheral_enable_two <= `PIF_RST_BYTE;
         peripheral_flags_two  <= `PIF_RST_BYTE;
         edge_select           <= `PIF_RST_EDGE_SELECT;
         status                <= 2'b00;
         mask                  <= 2'b00;
      end else begin
         peripheral_flags_two <= next_flags;
         if (wr && paddr_i == `PIF_OFS_INTERRUPT_CONTROL) begin
            interrupt_control <= pwdata_i[7:0];
         end
         if (wr && paddr_i == `PIF_OFS_PERIPHERAL_ENABLE_TWO) begin
            peripheral_enable_two <= pwdata_i[7:0] & `PIF_IMPL_MASK;
         end
         if (wr && paddr_i == `PIF_OFS_EDGE_SELECT) begin
            edge_select <= {2'b00, pwdata_i[5:0]};
         end
         if (wr && paddr_i == `PIF_OFS_MASK) begin
            mask <= pwdata_i[1:0];
         end
         if (wr && paddr_i == `PIF_OFS_STATUS) begin
            status <= (status & ~pwdata_i[1:0]) | stat_set;
         end else begin
            status <= status | stat_set;
         end
      end
   end

   // ----------------------------------------------------------------
   // Common scratch RAM, one array for all banks
   // ----------------------------------------------------------------
   always @(posedge core_clk_i) begin
      if (wr && ram_hit) begin
         common_ram[ram_idx] <= pwdata_i[7:0];
      end
   end

   // ----------------------------------------------------------------
   // Interrupt entry, the service routine preserves all other state
   // ----------------------------------------------------------------
   always @(posedge core_clk_i or posedge reset_i) begin
      if (reset_i) begin
         core_irq_o     <= 1'b0;
         push_pc_o      <= 1'b0;
         push_pc_data_o <= {`PIF_PC_W{1'b0}};
         ret_pc         <= {`PIF_PC_W{1'b0}};
         irq_o          <= 1'b0;
      end else begin
         core_irq_o <= core_req;
         push_pc_o  <= irq_ack_i;
         if (irq_ack_i) begin
            push_pc_data_o <= core_pc_i;
            ret_pc         <= core_pc_i;
         end
         irq_o <= |((status | stat_set) & mask);
      end
   end

   // ----------------------------------------------------------------
   // APB read and response
   // ----------------------------------------------------------------
   always @* begin
      next_rdata = 32'h0000_0000;
      next_err   = 1'b0;
      if (ram_hit) begin
         next_rdata = {24'h00_0000, common_ram[ram_idx]};
      end else begin
         case (paddr_i)
            `PIF_OFS_INTERRUPT_CONTROL:     next_rdata = {24'h00_0000, interrupt_control};
            `PIF_OFS_PERIPHERAL_ENABLE_TWO: next_rdata = {24'h00_0000, peripheral_enable_two};
            `PIF_OFS_PERIPHERAL_FLAGS_TWO:  next_rdata = {24'h00_0000, peripheral_flags_two};
            `PIF_OFS_EDGE_SELECT:           next_rdata = {24'h00_0000, edge_select};
            `PIF_OFS_STATUS:                next_rdata = {30'h0000_0000, status};
            `PIF_OFS_MASK:                  next_rdata = {30'h0000_0000, mask};
            `PIF_OFS_RET_PC:                next_rdata = {19'h0_0000, ret_pc};
            default:                        next_err   = 1'b1;
         endcase
      end
   end

   always @(posedge core_clk_i or posedge reset_i) begin
      if (reset_i) begin
         prdata_o  <= 32'h0000_0000;
         pready_o  <= 1'b0;
         pslverr_o <= 1'b0;
      end else begin
         pready_o  <= access;
         pslverr_o <= access & next_err;
         if (access && !pwrite_i) begin
            prdata_o <= next_rdata;
         end
      end
   end

endmodule // pif_flags

/* sim/pif_core_model.sv */
// Core stand-in that takes each new peripheral interrupt request once.
// Assumes one clock shared with the flag block.
`timescale 1ns/100ps
module pif_core_model (
   // Clock and reset
   input  wire        core_clk_i,
   input  wire        reset_i,
   // Request and entry
   input  wire        core_irq_i,
   output reg         irq_ack_o,
   output reg  [12:0] core_pc_o
);
   reg                seen;
   always @(posedge core_clk_i or posedge reset_i) begin
      if (reset_i) begin
         irq_ack_o <= 1'b0;
         seen      <= 1'b0;
         core_pc_o <= 13'h0a5;
      end else begin
         irq_ack_o <= core_irq_i & ~seen;
         seen      <= core_irq_i;
         core_pc_o <= core_pc_o + {12'h000, irq_ack_o};
      end
   end
endmodule // pif_core_model

/* sim/pif_flags_checker.sv */
// Concurrent checks on the ports of the flag block.
// Assumes it is bound to every instance of pif_flags.
`timescale 1ns/100ps
module pif_flags_checker (
   // Clock, reset and bus
   input wire        core_clk_i,
   input wire        reset_i,
   input wire        psel_i,
   input wire        penable_i,
   input wire        pwrite_i,
   input wire [11:0] paddr_i,
   input wire [31:0] pwdata_i,
   input wire [31:0] prdata_o,
   input wire        pready_o,
   // Events and core side
   input wire        desat_i,
   input wire        irq_ack_i,
   input wire [12:0] core_pc_i,
   input wire        core_irq_o,
   input wire        push_pc_o,
   input wire [12:0] push_pc_data_o,
   input wire        irq_o
);
   // ----------------------------------------------------------------
   // Shadows of control registers and checks
   // ----------------------------------------------------------------
   reg  [7:0] ic;
   reg  [7:0] en;
   reg  [7:0] mk;
   wire       acc = psel_i & penable_i & pready_o;
   always @(posedge core_clk_i or posedge reset_i) begin
      if (reset_i) begin
         ic <= 8'h00;
         en <= 8'h00;
         mk <= 8'h00;
      end else if (acc & pwrite_i) begin
         if (paddr_i == 12'h000) ic <= pwdata_i[7:0];
         if (paddr_i == 12'h004) en <= pwdata_i[7:0];
         if (paddr_i == 12'h014) mk <= pwdata_i[7:0];
      end
   end
   default clocking cb @(posedge core_clk_i); endclocking
   default disable iff (reset_i);
   chk_ready_single:
      assert property (pready_o |=> !pready_o) else $error("ready held too long");
   chk_bit_five_zero:
      assert property (acc && !pwrite_i && paddr_i == 12'h008 |-> !prdata_o[5])
      else $error("flag bit five read as one");
   chk_group_gate:
      assert property (core_irq_o |-> ic[7] && ic[6]) else $error("request without enables");
   chk_enable_gate:
      assert property (core_irq_o |-> en != 8'h00) else $error("request with no enable");
   chk_push_after_ack:
      assert property (irq_ack_i |=> push_pc_o && push_pc_data_o == $past(core_pc_i))
      else $error("return pc not pushed");
   chk_push_cause:
      assert property (push_pc_o |-> $past(irq_ack_i)) else $error("push without entry");
   chk_event_to_core:
      assert property ($rose(desat_i) && en[7] && ic[7:6] == 2'b11 |-> ##[1:5] core_irq_o)
      else $error("event did not reach core");
   chk_irq_mask_gate:
      assert property (irq_o |-> mk[1:0] != 2'b00) else $error("masked interrupt raised");
   cover property (irq_ack_i);
   cover property (irq_o);
   cover property (acc && !pwrite_i && paddr_i == 12'h008);
endmodule // pif_flags_checker
bind pif_flags pif_flags_checker pif_flags_checker_inst (.*);

/* sim/pif_flags_tb.sv */
// Self-checking bench of the flag block over APB with a core stand-in.
// Assumes the flag block, its checker and the core model are compiled.
`timescale 1ns/100ps
module pif_flags_tb;
   // ----------------------------------------------------------------
   // Stimulus, tasks and tests
   // ----------------------------------------------------------------
   reg         core_clk_i = 1'b0;
   reg         reset_i    = 1'b1;
   reg         psel       = 1'b0;
   reg         penable    = 1'b0;
   reg         pwrite     = 1'b0;
   reg  [11:0] paddr      = 12'h000;
   reg  [31:0] pwdata     = 32'h0;
   reg  [7:0]  ev         = 8'h00;
   wire [31:0] prdata;
   wire        pready, pslverr, core_irq, ack, push, irq;
   wire [12:0] pc, push_pc;
   reg  [31:0] rd;
   reg         err;
   integer     mismatches = 0;
   integer     tests_run  = 0;
   integer     i, s, n;
   always #2 core_clk_i = ~core_clk_i;
   pif_flags pif_flags_inst (.core_clk_i(core_clk_i), .reset_i(reset_i), .psel_i(psel),
      .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
      .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr), .desat_i(ev[7]),
      .conv_done_i(ev[6]), .overtemp_i(ev[4]), .out_overvolt_i(ev[3]),
      .gate_supply_low_i(ev[2]), .in_overvolt_i(ev[1]), .in_undervolt_i(ev[0]),
      .irq_ack_i(ack), .core_pc_i(pc), .core_irq_o(core_irq), .push_pc_o(push),
      .push_pc_data_o(push_pc), .irq_o(irq));
   pif_core_model pif_core_model_inst (.core_clk_i(core_clk_i), .reset_i(reset_i),
      .core_irq_i(core_irq), .irq_ack_o(ack), .core_pc_o(pc));
   task chk(input [31:0] seen, input [31:0] exp);
      begin
         tests_run = tests_run + 1;
         if (seen !== exp) begin
            mismatches = mismatches + 1;
            $display("Error at %0t: got %h, expected %h", $time, seen, exp);
         end
      end
   endtask
   task apb(input w, input [11:0] a, input [31:0] d);
      begin
         psel <= 1'b1;
         pwrite <= w;
         paddr <= a;
         pwdata <= d;
         @(posedge core_clk_i);
         penable <= 1'b1;
         n = 0;
         @(posedge core_clk_i);
         while (pready !== 1'b1 && n < 20) begin
            @(posedge core_clk_i);
            n = n + 1;
         end
         rd = prdata;
         err = pslverr;
         psel <= 1'b0;
         penable <= 1'b0;
         @(posedge core_clk_i);
      end
   endtask
   task pulse(input [7:0] m);
      begin
         ev <= m;
         repeat (6) @(posedge core_clk_i);
         ev <= 8'h00;
         repeat (3) @(posedge core_clk_i);
      end
   endtask
   task end_sim;
      begin
         $display("Comparisons %0d, mismatches %0d", tests_run, mismatches);
         if (mismatches == 0 && tests_run > 0)
            $display("== PASSED ==");
         else
            $display("== FAILED ==");
         $finish;
      end
   endtask
   initial begin
      #20000;
      mismatches = mismatches + 1;
      end_sim;
   end
   initial begin
      repeat (10) @(posedge core_clk_i);
      reset_i <= 1'b0;
      @(posedge core_clk_i);
      apb(0, 12'h008, 0);
      chk(rd, 32'h0);
      apb(0, 12'h00c, 0);
      chk(rd, 32'h15);
      apb(0, 12'h020, 0);
      chk({rd[30:0], err}, 32'h1);
      apb(1, 12'h008, 32'hff);
      apb(0, 12'h008, 0);
      chk(rd, 32'hdf);
      apb(1, 12'h008, 0);
      apb(1, 12'h014, 32'h1);
      for (s = 0; s < 2; s = s + 1) begin
         apb(1, 12'h00c, s ? 32'h2a : 32'h15);
         for (i = 0; i < 8; i = i + 1) begin
            if (i != 5) begin
               ev <= 8'h01 << i;
               repeat (6) @(posedge core_clk_i);
               apb(0, 12'h008, 0);
               chk(rd, (s && (i < 2 || i == 3)) ? 32'h0 : 32'h1 << i);
               ev <= 8'h00;
               repeat (6) @(posedge core_clk_i);
               apb(0, 12'h008, 0);
               chk(rd, 32'h1 << i);
               apb(1, 12'h008, 0);
            end
         end
      end
      chk({31'h0, irq}, 32'h1);
      apb(1, 12'h010, 32'h3);
      apb(1, 12'h014, 0);
      pulse(8'h80);
      chk({31'h0, irq}, 32'h0);
      apb(0, 12'h010, 0);
      chk(rd & 32'h1, 32'h1);
      apb(1, 12'h008, 0);
      apb(1, 12'h004, 32'h80);
      apb(1, 12'h000, 32'h80);
      pulse(8'h80);
      chk({31'h0, core_irq}, 32'h0);
      apb(1, 12'h008, 0);
      apb(1, 12'h000, 32'hc0);
      pulse(8'h80);
      chk({31'h0, core_irq}, 32'h1);
      apb(0, 12'h018, 0);
      chk(rd, 32'h0a5);
      apb(1, 12'h040, 32'h5a);
      apb(1, 12'h008, 0);
      chk({31'h0, core_irq}, 32'h0);
      apb(1, 12'h07c, 32'h3c);
      apb(0, 12'h040, 0);
      chk(rd & 32'hff, 32'h5a);
      apb(0, 12'h07c, 0);
      chk(rd & 32'hff, 32'h3c);
      end_sim;
   end
endmodule // pif_flags_tb
